/* File: hdl/serial_line_mode_pkg.sv */
// Shared constants and types for the serial line mode control block
package serial_line_mode_pkg;
    typedef enum logic [1:0] {
        MODE_RS232,
        MODE_RS422,
        MODE_RS485
    } line_mode_e;
    // Firmware serial interface setting values
    localparam logic [1:0] IFACE_RS232 = 2'h0;
    localparam logic [1:0] IFACE_RS422 = 2'h1;
    localparam logic [1:0] IFACE_AUTO = 2'h2;
    // Switch bit positions (switch 3 is reserved)
    localparam int SW_ONE = 0;
    localparam int SW_TWO = 1;
    // Routing buffer depth in bytes per direction
    localparam int BUF_DEPTH = 510;
    localparam int BUF_DEPTH_OLD = 255;
    localparam int BUF_AW = 9;
    // LED pulse time and cycle count at 125 MHz
    localparam int LED_PULSE_NS = 20000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int LED_PULSE_CYC = (LED_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LED_CW = 12;
    localparam logic [LED_CW-1:0] LED_ZERO = 12'h000;
    localparam logic [LED_CW-1:0] LED_ONE = 12'h001;
    localparam logic [BUF_AW-1:0] PTR_ZERO = 9'h000;
    localparam logic [BUF_AW-1:0] PTR_ONE = 9'h001;
    localparam logic [BUF_AW:0] CNT_ZERO = 10'h000;
    localparam logic [BUF_AW:0] CNT_ONE = 10'h001;
endpackage : serial_line_mode_pkg

/* File: hdl/serial_line_mode_control.sv */
// Serial line mode selection, RS485 direction, status LEDs and routing buffers
// What this block does
// - Two switches decode RS232, RS422 or RS485
// - Third switch ignored; reserved
// - Switch mode sampled only at power-up
// - Switch mode used only when setting is auto
// - RS422: transmit and RTS pairs always driven
// - RS485: drive only when sending; drop echo
// - RS485 idle: tri-state transmit, accept receive
// - RS485: no RTS or CTS pairs
// - Button at power-up selects serial upgrade mode
// - Running button press requests programming mode, except in upgrade mode
// - Green LED on, blinks off per packet
// - Red LED off, blinks on per collision
// - 510-byte buffer each direction, 255 older
module serial_line_mode_control #(
    parameter int LED_PULSE = serial_line_mode_pkg::LED_PULSE_CYC,
    parameter bit OLD_VARIANT = 1'b0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Board straps
    input wire logic [2:0] modeSwitch,
    input wire logic setupButton,
    input wire logic [1:0] ifaceSetting,
    // Mode status
    output logic [1:0] lineMode,
    output logic upgradeMode,
    output logic progRequest,
    // UART side
    input wire logic txSerial,
    input wire logic txBusy,
    input wire logic rtsLevel,
    output logic rxSerial,
    output logic ctsLevel,
    // Line transceiver side
    output logic txLine,
    output logic txLineOe,
    output logic rtsLine,
    output logic rtsLineOe,
    input wire logic rxLine,
    input wire logic ctsLine,
    // Ethernet events and LEDs
    input wire logic pktReceived,
    input wire logic collision,
    output logic ledGreen,
    output logic ledRed,
    // Network to serial buffer
    input wire logic [7:0] n2sData,
    input wire logic n2sValid,
    output logic n2sReady,
    output logic [7:0] n2sOutData,
    output logic n2sOutValid,
    input wire logic n2sOutReady,
    // Serial to network buffer
    input wire logic [7:0] s2nData,
    input wire logic s2nValid,
    output logic s2nReady,
    output logic [7:0] s2nOutData,
    output logic s2nOutValid,
    input wire logic s2nOutReady
);
    typedef logic [serial_line_mode_pkg::BUF_AW-1:0] ptr_t;
    typedef logic [serial_line_mode_pkg::BUF_AW:0] cnt_t;
    localparam cnt_t DEPTH = OLD_VARIANT ?
        cnt_t'(serial_line_mode_pkg::BUF_DEPTH_OLD) : cnt_t'(serial_line_mode_pkg::BUF_DEPTH);
    localparam logic [serial_line_mode_pkg::LED_CW-1:0] PULSE =
        serial_line_mode_pkg::LED_CW'(LED_PULSE);

    function automatic logic [1:0] decodeMode(input logic [2:0] sw, input logic [1:0] setting);
        logic [1:0] m;
        m = 2'(serial_line_mode_pkg::MODE_RS232);
        if (setting == serial_line_mode_pkg::IFACE_AUTO) begin
            // Switch 3 never looked at
            if (sw[serial_line_mode_pkg::SW_ONE] && sw[serial_line_mode_pkg::SW_TWO]) begin
                m = 2'(serial_line_mode_pkg::MODE_RS485);
            end else if (sw[serial_line_mode_pkg::SW_TWO]) begin
                m = 2'(serial_line_mode_pkg::MODE_RS422);
            end
        end else if (setting == serial_line_mode_pkg::IFACE_RS422) begin
            m = 2'(serial_line_mode_pkg::MODE_RS422);
        end
        return m;
    endfunction

    localparam cnt_t CNT_ONE = serial_line_mode_pkg::CNT_ONE;
    function automatic ptr_t wrapInc(input ptr_t p);
        return (cnt_t'(p) == DEPTH - CNT_ONE) ? serial_line_mode_pkg::PTR_ZERO :
            p + serial_line_mode_pkg::PTR_ONE;
    endfunction

    // Strap capture: first clocked cycle after reset release
    logic captured, next_captured;
    logic [1:0] modeReg, next_modeReg;
    logic upgrade, next_upgrade;
    logic btnPrev, next_btnPrev;
    logic prog, next_prog;

    always_comb begin
        next_captured = 1'b1;
        next_modeReg = modeReg;
        next_upgrade = upgrade;
        next_btnPrev = setupButton;
        next_prog = 1'b0;
        if (!captured) begin
            next_modeReg = decodeMode(modeSwitch, ifaceSetting);
            next_upgrade = setupButton;
        end else if (!upgrade && setupButton && !btnPrev) begin
            next_prog = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            captured <= 1'b0;
            modeReg <= 2'(serial_line_mode_pkg::MODE_RS232);
            upgrade <= 1'b0;
            btnPrev <= 1'b1;
            prog <= 1'b0;
        end else begin
            captured <= next_captured;
            modeReg <= next_modeReg;
            upgrade <= next_upgrade;
            btnPrev <= next_btnPrev;
            prog <= next_prog;
        end
    end

    assign lineMode = modeReg;
    assign upgradeMode = upgrade;
    assign progRequest = prog;

    // Line drivers
    logic is485;
    logic sending;
    assign is485 = (modeReg == 2'(serial_line_mode_pkg::MODE_RS485));
    // txBusy covers the final stop bit, so the pair is released only after it
    assign sending = txBusy || !txSerial;
    logic txLineQ, next_txLineQ, txOeQ, next_txOeQ, rtsQ, next_rtsQ, rtsOeQ, next_rtsOeQ;
    logic rxQ, next_rxQ, ctsQ, next_ctsQ;

    always_comb begin
        next_txLineQ = txSerial;
        next_txOeQ = captured;
        next_rtsQ = rtsLevel;
        next_rtsOeQ = captured;
        next_rxQ = rxLine;
        next_ctsQ = ctsLine;
        if (is485) begin
            next_txOeQ = captured && sending;
            next_rtsOeQ = 1'b0;
            next_ctsQ = 1'b0;
            // Own echo would corrupt receive; hold idle level instead
            next_rxQ = sending ? 1'b1 : rxLine;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            txLineQ <= 1'b1;
            txOeQ <= 1'b0;
            rtsQ <= 1'b0;
            rtsOeQ <= 1'b0;
            rxQ <= 1'b1;
            ctsQ <= 1'b0;
        end else begin
            txLineQ <= next_txLineQ;
            txOeQ <= next_txOeQ;
            rtsQ <= next_rtsQ;
            rtsOeQ <= next_rtsOeQ;
            rxQ <= next_rxQ;
            ctsQ <= next_ctsQ;
        end
    end

    assign txLine = txLineQ;
    assign txLineOe = txOeQ;
    assign rtsLine = rtsQ;
    assign rtsLineOe = rtsOeQ;
    assign rxSerial = rxQ;
    assign ctsLevel = ctsQ;

    // Ethernet LEDs: a pulse stretcher each, retriggered by new events
    logic [serial_line_mode_pkg::LED_CW-1:0] rxCnt, next_rxCnt, colCnt, next_colCnt;

    always_comb begin
        next_rxCnt = (rxCnt != serial_line_mode_pkg::LED_ZERO) ?
            rxCnt - serial_line_mode_pkg::LED_ONE : rxCnt;
        next_colCnt = (colCnt != serial_line_mode_pkg::LED_ZERO) ?
            colCnt - serial_line_mode_pkg::LED_ONE : colCnt;
        if (pktReceived) begin
            next_rxCnt = PULSE;
        end
        if (collision) begin
            next_colCnt = PULSE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rxCnt <= serial_line_mode_pkg::LED_ZERO;
            colCnt <= serial_line_mode_pkg::LED_ZERO;
        end else begin
            rxCnt <= next_rxCnt;
            colCnt <= next_colCnt;
        end
    end

    assign ledGreen = (rxCnt == serial_line_mode_pkg::LED_ZERO);
    assign ledRed = (colCnt != serial_line_mode_pkg::LED_ZERO);

    // Routing buffers, one per direction; index 0 is network to serial
    logic [7:0] mem0 [serial_line_mode_pkg::BUF_DEPTH];
    logic [7:0] mem1 [serial_line_mode_pkg::BUF_DEPTH];
    ptr_t wp [2], rp [2], next_wp [2], next_rp [2];
    cnt_t cnt [2], next_cnt [2];
    logic inV [2], inR [2], outV [2], outR [2], push [2], pop [2];

    assign inV[0] = n2sValid;
    assign inV[1] = s2nValid;
    assign outR[0] = n2sOutReady;
    assign outR[1] = s2nOutReady;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            inR[i] = (cnt[i] != DEPTH);
            outV[i] = (cnt[i] != serial_line_mode_pkg::CNT_ZERO);
            push[i] = inV[i] && inR[i];
            pop[i] = outV[i] && outR[i];
            next_wp[i] = push[i] ? wrapInc(wp[i]) : wp[i];
            next_rp[i] = pop[i] ? wrapInc(rp[i]) : rp[i];
            next_cnt[i] = cnt[i] + cnt_t'(push[i]) - cnt_t'(pop[i]);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push[0]) begin
            mem0[wp[0]] <= n2sData;
        end
        if (push[1]) begin
            mem1[wp[1]] <= s2nData;
        end
        for (int i = 0; i < 2; i++) begin
            if (!rst_b) begin
                wp[i] <= serial_line_mode_pkg::PTR_ZERO;
                rp[i] <= serial_line_mode_pkg::PTR_ZERO;
                cnt[i] <= serial_line_mode_pkg::CNT_ZERO;
            end else begin
                wp[i] <= next_wp[i];
                rp[i] <= next_rp[i];
                cnt[i] <= next_cnt[i];
            end
        end
    end

    assign n2sReady = inR[0];
    assign s2nReady = inR[1];
    assign n2sOutValid = outV[0];
    assign s2nOutValid = outV[1];
    assign n2sOutData = mem0[rp[0]];
    assign s2nOutData = mem1[rp[1]];
endmodule // serial_line_mode_control

/* File: sim/serial_line_mode_checker.sv */
// Port assertions for the serial line mode control block
module serial_line_mode_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Inputs watched
    input wire logic txSerial,
    input wire logic txBusy,
    input wire logic rxLine,
    input wire logic pktReceived,
    input wire logic collision,
    // Outputs watched
    input wire logic [1:0] lineMode,
    input wire logic txLineOe,
    input wire logic rtsLineOe,
    input wire logic rxSerial,
    input wire logic ctsLevel,
    input wire logic ledGreen,
    input wire logic ledRed
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] upCnt;
    logic live, is485, sending;
    // Wait out capture and enable latency before judging the mode
    always_ff @(posedge sys_clk) begin
        upCnt <= !rst_b ? 2'h0 : (live ? upCnt : upCnt + 2'h1);
    end
    assign live = upCnt == 2'h3;
    assign is485 = live && lineMode == serial_line_mode_pkg::MODE_RS485;
    assign sending = txBusy || !txSerial;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_mode_hold; live |-> $stable(lineMode); endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("line mode moved");
    property p_duplex; live && lineMode == 2'h1 |-> txLineOe && rtsLineOe; endproperty
    a_duplex: assert property (p_duplex) else $error("pairs not driven");
    property p_no_hs; is485 |-> !rtsLineOe && !ctsLevel; endproperty
    a_no_hs: assert property (p_no_hs) else $error("handshake in half duplex");
    property p_drive; is485 && sending |=> txLineOe && rxSerial; endproperty
    a_drive: assert property (p_drive) else $error("send not driven");
    property p_release; is485 && !sending |=> !txLineOe; endproperty
    a_release: assert property (p_release) else $error("idle pair driven");
    property p_listen; is485 && !sending |=> rxSerial == $past(rxLine); endproperty
    a_listen: assert property (p_listen) else $error("receive lost");
    property p_green; pktReceived |=> !ledGreen; endproperty
    a_green: assert property (p_green) else $error("green did not blink");
    property p_red; collision |=> ledRed; endproperty
    a_red: assert property (p_red) else $error("red did not blink");
endmodule // serial_line_mode_checker

bind serial_line_mode_control serial_line_mode_checker chk (
    .sys_clk, .rst_b, .txSerial, .txBusy, .rxLine, .pktReceived, .collision, .lineMode,
    .txLineOe, .rtsLineOe, .rxSerial, .ctsLevel, .ledGreen, .ledRed
);

/* File: sim/line_partner.sv */
// Far-side transceiver model: two-wire bus and handshake source
module line_partner (
    input wire logic txLine,
    input wire logic txLineOe,
    input wire logic farBit,
    input wire logic ctsReq,
    output logic rxLine,
    output logic ctsLine
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pairs tied together, so our own driver echoes onto receive
    assign rxLine = txLineOe ? txLine : farBit;
    assign ctsLine = ctsReq;
endmodule // line_partner

/* File: sim/tb.sv */
// Self-checking bench for the serial line mode control block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rst_b = 1'b0, setupButton = 1'b0, txSerial = 1'b1, txBusy = 1'b0;
    logic rtsLevel = 1'b1, pktReceived = 1'b0, collision = 1'b0, farBit = 1'b1, ctsReq = 1'b1;
    logic n2sValid = 1'b0, s2nValid = 1'b0, n2sOutReady = 1'b0, s2nOutReady = 1'b0;
    logic [2:0] modeSwitch = 3'h0;
    logic [1:0] ifaceSetting = 2'h2, lineMode;
    logic [7:0] n2sData = 8'h00, s2nData = 8'h00, n2sOutData, s2nOutData;
    logic upgradeMode, progRequest, rxSerial, ctsLevel, txLine, txLineOe, rtsLine, rtsLineOe;
    logic rxLine, ctsLine, ledGreen, ledRed, n2sReady, n2sOutValid, s2nReady, s2nOutValid;
    int errCount = 0, nTests = 0, pulses;
    logic oldReady, oldValid;
    logic [7:0] oldData;
    logic [2:0] swTab [9] = '{3'h0, 3'h2, 3'h3, 3'h7, 3'h4, 3'h3, 3'h3, 3'h1, 3'h3};
    logic [1:0] ifTab [9] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h0, 2'h1, 2'h2, 2'h3};
    logic [1:0] mdTab [9] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0};
    serial_line_mode_control #(.LED_PULSE(4), .OLD_VARIANT(1'b0)) uut (
        .sys_clk, .rst_b, .modeSwitch, .setupButton, .ifaceSetting, .lineMode, .upgradeMode,
        .progRequest, .txSerial, .txBusy, .rtsLevel, .rxSerial, .ctsLevel, .txLine, .txLineOe,
        .rtsLine, .rtsLineOe, .rxLine, .ctsLine, .pktReceived, .collision, .ledGreen, .ledRed,
        .n2sData, .n2sValid, .n2sReady, .n2sOutData, .n2sOutValid, .n2sOutReady, .s2nData,
        .s2nValid, .s2nReady, .s2nOutData, .s2nOutValid, .s2nOutReady
    );
    // Older variant shares the stimulus; only its network to serial buffer is judged
    serial_line_mode_control #(.LED_PULSE(4), .OLD_VARIANT(1'b1)) uutOld (
        .sys_clk, .rst_b, .modeSwitch, .setupButton, .ifaceSetting, .lineMode(), .upgradeMode(),
        .progRequest(), .txSerial, .txBusy, .rtsLevel, .rxSerial(), .ctsLevel(), .txLine(),
        .txLineOe(), .rtsLine(), .rtsLineOe(), .rxLine, .ctsLine, .pktReceived, .collision,
        .ledGreen(), .ledRed(), .n2sData, .n2sValid, .n2sReady(oldReady),
        .n2sOutData(oldData), .n2sOutValid(oldValid), .n2sOutReady, .s2nData, .s2nValid,
        .s2nReady(), .s2nOutData(), .s2nOutValid(), .s2nOutReady
    );
    line_partner far (.txLine, .txLineOe, .farBit, .ctsReq, .rxLine, .ctsLine);
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic tick(input int n = 1);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        nTests++;
        if (got !== exp) begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Straps held past the first edge after release, where they are captured
    task automatic restart(input logic [2:0] sw, input logic btn, input logic [1:0] ifc);
        rst_b = 1'b0;
        modeSwitch = sw;
        setupButton = btn;
        ifaceSetting = ifc;
        tick(4);
        rst_b = 1'b1;
        tick(4);
    endtask
    task automatic reportAndStop();
        $display("Checks %0d, mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        errCount++;
        reportAndStop();
    end
    initial begin
        for (int k = 0; k < 9; k++) begin
            restart(swTab[k], k == 1, ifTab[k]);
            chk("lineMode", mdTab[k], lineMode);
            chk("upgradeMode", k == 1, upgradeMode);
            modeSwitch = ~swTab[k];
            ifaceSetting = ~ifTab[k];
            setupButton = 1'b0;
            tick(2);
            pulses = 0;
            setupButton = 1'b1;
            repeat (4) begin
                tick();
                if (progRequest === 1'b1) begin
                    pulses++;
                end
            end
            chk("progRequest", k != 1, 8'(pulses));
            chk("lineMode", mdTab[k], lineMode);
        end
        restart(3'h3, 1'b0, 2'h2);
        chk("rtsLineOe", 1'b0, rtsLineOe);
        chk("ctsLevel", 1'b0, ctsLevel);
        chk("txLineOe", 1'b0, txLineOe);
        txBusy = 1'b1;
        txSerial = 1'b0;
        tick(2);
        chk("txLineOe", 1'b1, txLineOe);
        chk("rxSerial", 1'b1, rxSerial);
        txSerial = 1'b1;
        tick(2);
        chk("txLineOe", 1'b1, txLineOe);
        txBusy = 1'b0;
        farBit = 1'b0;
        tick(2);
        chk("txLineOe", 1'b0, txLineOe);
        chk("rxSerial", 1'b0, rxSerial);
        restart(3'h2, 1'b0, 2'h2);
        chk("txLineOe", 1'b1, txLineOe);
        chk("rtsLineOe", 1'b1, rtsLineOe);
        txSerial = 1'b0;
        rtsLevel = 1'b0;
        tick(2);
        chk("txLine", 1'b0, txLine);
        chk("rtsLine", 1'b0, rtsLine);
        chk("ctsLevel", 1'b1, ctsLevel);
        pktReceived = 1'b1;
        collision = 1'b1;
        tick();
        pktReceived = 1'b0;
        collision = 1'b0;
        tick();
        chk("ledGreen", 1'b0, ledGreen);
        chk("ledRed", 1'b1, ledRed);
        tick(2);
        chk("ledGreen", 1'b0, ledGreen);
        chk("ledRed", 1'b1, ledRed);
        tick();
        chk("ledGreen", 1'b1, ledGreen);
        chk("ledRed", 1'b0, ledRed);
        // Far side stalls while both buffers fill up to refusal
        for (int i = 0; i < 511; i++) begin
            n2sValid = 1'b1;
            s2nValid = 1'b1;
            n2sData = i[7:0];
            s2nData = i[7:0];
            chk("n2sReady", i < 510, n2sReady);
            chk("s2nReady", i < 510, s2nReady);
            chk("oldReady", i < 255, oldReady);
            tick();
        end
        n2sValid = 1'b0;
        s2nValid = 1'b0;
        n2sOutReady = 1'b1;
        s2nOutReady = 1'b1;
        for (int i = 0; i < 511; i++) begin
            chk("n2sOutValid", i < 510, n2sOutValid);
            chk("s2nOutValid", i < 510, s2nOutValid);
            chk("oldValid", i < 255, oldValid);
            if (i < 510) begin
                chk("n2sOutData", i[7:0], n2sOutData);
                chk("s2nOutData", i[7:0], s2nOutData);
            end
            if (i < 255) begin
                chk("oldData", i[7:0], oldData);
            end
            tick();
        end
        // Wrapped pointers reused, then push and pop in one cycle
        n2sValid = 1'b1;
        s2nValid = 1'b1;
        n2sData = 8'hC3;
        s2nData = 8'hC3;
        tick();
        chk("n2sOutData", 8'hC3, n2sOutData);
        chk("s2nOutData", 8'hC3, s2nOutData);
        chk("oldData", 8'hC3, oldData);
        n2sData = 8'h3C;
        s2nData = 8'h3C;
        tick();
        chk("n2sOutValid", 1'b1, n2sOutValid);
        chk("n2sOutData", 8'h3C, n2sOutData);
        chk("s2nOutData", 8'h3C, s2nOutData);
        chk("oldData", 8'h3C, oldData);
        n2sValid = 1'b0;
        s2nValid = 1'b0;
        tick();
        chk("n2sOutValid", 1'b0, n2sOutValid);
        chk("s2nOutValid", 1'b0, s2nOutValid);
        chk("oldValid", 1'b0, oldValid);
        reportAndStop();
    end
endmodule // tb
